// *** src/bw_usage_monitor.v ***
// bandwidth usage monitor instances with wishbone register access
// Operation
// - filter on the request partition id, never a narrowed internal id
// - any instance count up to two to the sixteenth minus one
// - instance select routes control, filter, counter and capture registers to one instance
// - count payload bytes of matching writes downstream and reads upstream
// - filter selects by read, write, partition, perf group and enable
// - shift enable zero gives raw byte count, one gives scaled count
// - scaled count is rounded byte count shifted right by shift constant
// - shift constant is a fixed build choice sized against overflow
// - capture event copies counter to capture, optional clear
// - writing filter or control sets the not ready flag
// - capture copies not ready flag first, then clears it
// - capture source select; local trigger exists only when present flag is one
// - long counter exists only when long counter id bit is one
// - long capture exists when both long and capture id bits are one
// - long counter and long capture are never scaled
// - long count 44 bits with upper bits zero, or 63 bits wide
// - long counter register carries its own not ready flag
// - long overflow sets long overflow flag; irq when its enable set
// - short overflow irq has own enable; long signalling unaffected
// - one freeze on overflow control covers short and long counters
// - clear after capture zeroes count right after the capture
// - short overflow flag set on overflow, cleared only by writing zero
// - writing one at trigger bit of local trigger register fires capture
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`include "bw_monitor_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module bw_usage_monitor #(
    parameter NUM_INST = 4,
    parameter INST_BITS = 2,
    parameter PART_BITS = 16,
    parameter GROUP_BITS = 8,
    parameter BYTES_BITS = 8,
    parameter SCALE = 3,
    parameter HAS_LONG = 1,
    parameter HAS_CAPTURE = 1,
    parameter LONG_WIDE_SEL = 0,
    parameter HAS_LOCAL_TRIG = 1,
    parameter NUM_EXT_EVENTS = 6
)(
    // clock and reset
    input wire CLK,
    input wire RST,
    // wishbone slave
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [7:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    output reg [31:0] DAT_O,
    output reg ACK_O,
    // observed transfer, same clock domain
    input wire XFER_VALID,
    input wire XFER_IS_WRITE,
    input wire [PART_BITS-1:0] XFER_PARTITION_ID,
    input wire [GROUP_BITS-1:0] XFER_PERF_GROUP,
    input wire [BYTES_BITS-1:0] XFER_BYTES,
    // external capture events, one-cycle pulses from same domain
    input wire [NUM_EXT_EVENTS-1:0] CAPTURE_EVENT,
    // overflow interrupt level
    output reg OVERFLOW_IRQ
);
    localparam LW = `LONG_WIDE;
    localparam LEN_BITS = LONG_WIDE_SEL ? `LONG_WIDE : `LONG_NARROW;
    // built at 64 bits so that the mask never carries a dropped top bit
    localparam [LW:0] LONG_MAX = (64'h1 << LEN_BITS) - 64'h1;
    localparam [LW:0] SHORT_MAX = {{(LW+1-`SHORT_WIDTH){1'b0}}, {`SHORT_WIDTH{1'b1}}};
    localparam [LW:0] SCALE_UNIT = 64'h1 << SCALE;

    // ***************************************************************
    // instance select and per-instance state
    // ***************************************************************
    reg [INST_BITS-1:0] inst_sel;
    reg [31:0] ctl [0:NUM_INST-1];
    reg [31:0] flt [0:NUM_INST-1];
    reg [LW-1:0] raw_count [0:NUM_INST-1];
    reg [LW-1:0] long_count [0:NUM_INST-1];
    reg short_not_ready_flag [0:NUM_INST-1];
    reg long_not_ready_flag [0:NUM_INST-1];
    reg [31:0] short_capt [0:NUM_INST-1];
    reg [LW-1:0] long_capt [0:NUM_INST-1];
    reg long_capt_not_ready_flag [0:NUM_INST-1];

    // ***************************************************************
    // bus decode
    // ***************************************************************
    wire req = CYC_I & STB_I & ~ACK_O;
    wire wr = req & WE_I;
    wire [31:0] wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    wire inst_ok = ({{(32-INST_BITS){1'b0}}, inst_sel} < NUM_INST);
    wire wr_ctl = wr & inst_ok & (ADR_I == `OFS_CONTROL);
    wire wr_flt = wr & inst_ok & (ADR_I == `OFS_FILTER);
    wire wr_cnt = wr & inst_ok & (ADR_I == `OFS_SHORT_COUNTER);
    wire wr_llo = wr & inst_ok & (ADR_I == `OFS_LONG_COUNTER_LO) & (HAS_LONG != 0);
    wire wr_lhi = wr & inst_ok & (ADR_I == `OFS_LONG_COUNTER_HI) & (HAS_LONG != 0);
    // local trigger only fires when the generator is built in
    wire local_fire = wr & (HAS_LOCAL_TRIG != 0) & (ADR_I == `OFS_LOCAL_TRIGGER)
        & SEL_I[0] & DAT_I[`TRIGGER_BIT];

    // ***************************************************************
    // instance select register
    // ***************************************************************
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
            inst_sel <= {INST_BITS{1'b0}};
        else if (wr & (ADR_I == `OFS_INSTANCE_SELECT))
            inst_sel <= (DAT_I[INST_BITS-1:0] & wmask[INST_BITS-1:0]) | (inst_sel & ~wmask[INST_BITS-1:0]);
    end

    // ***************************************************************
    // counting engine, one generate slice per instance
    // ***************************************************************
    wire [NUM_INST-1:0] short_ovf_any;
    wire [NUM_INST-1:0] long_ovf_any;
    genvar g;
    generate
        for (g = 0; g < NUM_INST; g = g + 1)
        begin : inst
            wire [31:0] c = ctl[g];
            wire [31:0] f = flt[g];
            wire [2:0] src = c[`CTL_CAPT_SEL_HI:`CTL_CAPT_SEL_LO];
            // external events 0..5 plus local generator at select 7
            wire ext_hit = ({29'h0, src} < NUM_EXT_EVENTS) ? CAPTURE_EVENT[src] : 1'b0;
            wire capture = c[`CTL_ENABLE] & (HAS_CAPTURE != 0) & (ext_hit
                | ((src == `LOCAL_CAPTURE_SEL) & local_fire));
            wire sel_me = (inst_sel == g[INST_BITS-1:0]);
            // the request partition id from the transfer is compared directly
            wire match = XFER_VALID & c[`CTL_ENABLE]
                & (XFER_IS_WRITE ? f[`FLT_MATCH_WRITE] : f[`FLT_MATCH_READ])
                & (~f[`FLT_MATCH_PARTITION] | (XFER_PARTITION_ID == f[`FLT_PARTITION_HI:`FLT_PARTITION_LO]))
                & (~f[`FLT_MATCH_GROUP] | (XFER_PERF_GROUP == f[`FLT_GROUP_HI:`FLT_GROUP_LO]));
            wire [LW:0] add = match ? {{(LW+1-BYTES_BITS){1'b0}}, XFER_BYTES} : {(LW+1){1'b0}};
            wire clr = capture & c[`CTL_CLEAR_AFTER_CAPTURE];
            // bytes arriving with a clearing capture go into the fresh count
            wire [LW:0] raw_base = clr ? {(LW+1){1'b0}} : {1'b0, raw_count[g]};
            wire [LW:0] long_base = clr ? {(LW+1){1'b0}} : {1'b0, long_count[g]};
            wire [LW:0] raw_sum = raw_base + add;
            wire [LW:0] long_sum = long_base + add;
            // scaled view rounds to nearest 2^SCALE then shifts
            wire [LW:0] rounded = ({1'b0, raw_count[g]} + (SCALE_UNIT >> 1)) >> SCALE;
            wire [LW:0] short_view = c[`CTL_SHIFT_ENABLE] ? rounded : {1'b0, raw_count[g]};
            wire [LW:0] raw_sum_view = c[`CTL_SHIFT_ENABLE] ? (raw_sum >> SCALE) : raw_sum;
            wire s_ovf = (raw_sum_view > SHORT_MAX);
            wire l_ovf = (HAS_LONG != 0) & (long_sum > LONG_MAX);
            // frozen counters stop after either flag is set
            wire frozen = c[`CTL_FREEZE] & (c[`CTL_SHORT_OFLOW] | c[`CTL_LONG_OFLOW]);
            assign short_ovf_any[g] = c[`CTL_SHORT_OFLOW] & c[`CTL_SHORT_IRQ_EN];
            assign long_ovf_any[g] = c[`CTL_LONG_OFLOW] & c[`CTL_LONG_IRQ_EN];

            // counters, flags and captures
            always @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    ctl[g] <= 32'h00000000;
                    flt[g] <= 32'h00000000;
                    raw_count[g] <= {LW{1'b0}};
                    long_count[g] <= {LW{1'b0}};
                    short_not_ready_flag[g] <= 1'b1;
                    long_not_ready_flag[g] <= 1'b1;
                    short_capt[g] <= 32'h00000000;
                    long_capt[g] <= {LW{1'b0}};
                    long_capt_not_ready_flag[g] <= 1'b0;
                end
                else
                begin
                    if (capture)
                    begin
                        // copy count and flag before the flag drops
                        short_capt[g] <= {short_not_ready_flag[g], short_view[30:0]};
                        long_capt[g] <= long_count[g] & LONG_MAX[LW-1:0];
                        long_capt_not_ready_flag[g] <= long_not_ready_flag[g];
                    end
                    if (sel_me & wr_cnt)
                        raw_count[g] <= {{(LW-31){1'b0}}, (c[`CTL_SHIFT_ENABLE] ? 31'h0 : DAT_I[30:0])};
                    else if (!frozen || clr)
                        raw_count[g] <= s_ovf ? {LW{1'b0}} : raw_sum[LW-1:0];
                    if (sel_me & wr_llo)
                        long_count[g] <= {long_count[g][LW-1:32], DAT_I};
                    else if (sel_me & wr_lhi)
                        long_count[g] <= {DAT_I[30:0], long_count[g][31:0]} & LONG_MAX[LW-1:0];
                    else if ((!frozen || clr) && (HAS_LONG != 0))
                        long_count[g] <= long_sum[LW-1:0] & LONG_MAX[LW-1:0];
                    // not ready: set by config writes, cleared after capture
                    if (sel_me & (wr_ctl | wr_flt))
                    begin
                        short_not_ready_flag[g] <= 1'b1;
                        long_not_ready_flag[g] <= 1'b1;
                    end
                    else if (capture)
                    begin
                        short_not_ready_flag[g] <= 1'b0;
                        long_not_ready_flag[g] <= 1'b0;
                    end
                    else if (sel_me & wr_cnt)
                        short_not_ready_flag[g] <= DAT_I[`NOT_READY_FLAG_BIT];
                    else if (sel_me & wr_lhi)
                        long_not_ready_flag[g] <= DAT_I[31];
                    if (sel_me & wr_flt)
                        flt[g] <= (DAT_I & wmask) | (flt[g] & ~wmask);
                    // control: overflow set wins over a software clear
                    if (sel_me & wr_ctl)
                        ctl[g] <= ((((DAT_I & wmask) | (c & ~wmask)) & `CTL_WRITE_MASK)
                            | ((s_ovf & ~frozen) ? 32'h00000020 : 32'h0)
                            | ((l_ovf & ~frozen) ? 32'h00000040 : 32'h0));
                    else
                        ctl[g] <= c | ((s_ovf & ~frozen) ? 32'h00000020 : 32'h0)
                            | ((l_ovf & ~frozen) ? 32'h00000040 : 32'h0);
                end
            end
        end
    endgenerate

    // ***************************************************************
    // interrupt output
    // ***************************************************************
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
            OVERFLOW_IRQ <= 1'b0;
        else
            OVERFLOW_IRQ <= (|short_ovf_any) | (|long_ovf_any);
    end

    // ***************************************************************
    // read mux and acknowledge
    // ***************************************************************
    reg [31:0] rd;
    reg [LW:0] sv;
    always @*
    begin
        rd = `BUS_ERR_DATA;
        sv = {(LW+1){1'b0}};
        if (inst_ok)
            sv = ctl[inst_sel][`CTL_SHIFT_ENABLE]
                ? (({1'b0, raw_count[inst_sel]} + (SCALE_UNIT >> 1)) >> SCALE)
                : {1'b0, raw_count[inst_sel]};
        case (ADR_I)
            `OFS_INSTANCE_SELECT: rd = {{(32-INST_BITS){1'b0}}, inst_sel};
            `OFS_BW_ID: rd = {HAS_CAPTURE != 0, HAS_LONG != 0, LONG_WIDE_SEL != 0, 5'h0, SCALE[7:0], NUM_INST[15:0]};
            `OFS_MONITOR_ID: rd = {31'h0, HAS_LOCAL_TRIG != 0};
            default:
            begin
                if (inst_ok)
                begin
                    case (ADR_I)
                        `OFS_CONTROL: rd = ctl[inst_sel];
                        `OFS_FILTER: rd = flt[inst_sel];
                        `OFS_SHORT_COUNTER: rd = {short_not_ready_flag[inst_sel], sv[30:0]};
                        `OFS_SHORT_CAPTURE: rd = short_capt[inst_sel];
                        `OFS_LONG_COUNTER_LO: rd = (HAS_LONG != 0) ? long_count[inst_sel][31:0] : 32'h0;
                        `OFS_LONG_COUNTER_HI: rd = (HAS_LONG != 0) ? {long_not_ready_flag[inst_sel], long_count[inst_sel][62:32]} : 32'h0;
                        `OFS_LONG_CAPTURE_LO: rd = (HAS_LONG != 0) ? long_capt[inst_sel][31:0] : 32'h0;
                        `OFS_LONG_CAPTURE_HI: rd = (HAS_LONG != 0) ? {long_capt_not_ready_flag[inst_sel], long_capt[inst_sel][62:32]} : 32'h0;
                        default: rd = `BUS_ERR_DATA;
                    endcase
                end
            end
        endcase
    end

    // single-cycle ack; unmapped reads return zero, writes ignored
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
        end
        else
        begin
            ACK_O <= req;
            DAT_O <= (req & ~WE_I) ? rd : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// *** src/bw_monitor_defs.vh ***
// register offsets, field positions, masks and widths of the bandwidth usage monitor
`ifndef BW_MONITOR_DEFS_VH
`define BW_MONITOR_DEFS_VH
// ***************************************************************
// register byte offsets
// ***************************************************************
`define OFS_INSTANCE_SELECT 8'h00
`define OFS_CONTROL 8'h04
`define OFS_FILTER 8'h08
`define OFS_SHORT_COUNTER 8'h0c
`define OFS_SHORT_CAPTURE 8'h10
`define OFS_LONG_COUNTER_LO 8'h14
`define OFS_LONG_COUNTER_HI 8'h18
`define OFS_LONG_CAPTURE_LO 8'h1c
`define OFS_LONG_CAPTURE_HI 8'h20
`define OFS_BW_ID 8'h24
`define OFS_MONITOR_ID 8'h28
`define OFS_LOCAL_TRIGGER 8'h2c
// ***************************************************************
// control register fields
// ***************************************************************
`define CTL_SHIFT_ENABLE 0
`define CTL_CLEAR_AFTER_CAPTURE 1
`define CTL_FREEZE 2
`define CTL_SHORT_IRQ_EN 3
`define CTL_LONG_IRQ_EN 4
`define CTL_SHORT_OFLOW 5
`define CTL_LONG_OFLOW 6
`define CTL_CAPT_SEL_LO 8
`define CTL_CAPT_SEL_HI 10
`define CTL_ENABLE 31
`define CTL_WRITE_MASK 32'h800007ff
// ***************************************************************
// filter register fields
// ***************************************************************
`define FLT_PARTITION_LO 0
`define FLT_PARTITION_HI 15
`define FLT_GROUP_LO 16
`define FLT_GROUP_HI 23
`define FLT_MATCH_READ 24
`define FLT_MATCH_WRITE 25
`define FLT_MATCH_GROUP 26
`define FLT_MATCH_PARTITION 27
// ***************************************************************
// other fields and constants
// ***************************************************************
`define NOT_READY_FLAG_BIT 31
`define TRIGGER_BIT 0
`define LOCAL_CAPTURE_SEL 3'h7
`define SHORT_WIDTH 31
`define LONG_WIDE 63
`define LONG_NARROW 44
`define BUS_ERR_DATA 32'h00000000
`endif

// *** testbench/bw_monitor_assertions.sv ***
// concurrent checks on the register port of the bandwidth monitor
`timescale 1ns/1ns
`default_nettype none
module bw_monitor_checker #(
    parameter NUM_INST = 4,
    parameter SCALE = 3,
    parameter HAS_LONG = 1,
    parameter HAS_CAPTURE = 1,
    parameter LONG_WIDE_SEL = 0,
    parameter NUM_EXT_EVENTS = 6
)(
    // clock and reset
    input wire CLK,
    input wire RST,
    // wishbone slave
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [7:0] ADR_I,
    input wire [31:0] DAT_I,
    input wire [31:0] DAT_O,
    input wire ACK_O,
    // capture pulses
    input wire [NUM_EXT_EVENTS-1:0] CAPTURE_EVENT
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    wire req = CYC_I && STB_I && !ACK_O;
    wire rd = req && !WE_I;
    reg [15:0] inst;
    // a write to an absent instance is ignored, so only live ones are judged
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
            inst <= 16'h0;
        else if (req && WE_I && ADR_I == 8'h00)
            inst <= DAT_I[15:0];
    end
    // config write, then the next request reads the short counter
    sequence cfg_write;
        req && WE_I && (ADR_I == 8'h04 || ADR_I == 8'h08) && inst < NUM_INST && CAPTURE_EVENT == 0;
    endsequence
    sequence ctr_read;
        rd && ADR_I == 8'h0c && CAPTURE_EVENT == 0;
    endsequence
    chk_ack_follows_req: assert property (req |=> ACK_O)
        else $error("request not acknowledged next cycle");
    chk_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("acknowledge longer than one cycle");
    chk_ack_has_cause: assert property ($rose(ACK_O) |-> $past(req))
        else $error("acknowledge without request");
    chk_idle_data_zero: assert property (!ACK_O |-> DAT_O == 32'h0)
        else $error("read data outside acknowledge");
    chk_unmapped_zero: assert property (rd && ADR_I > 8'h2c |=> DAT_O == 32'h0)
        else $error("unmapped read not zero");
    chk_id_fields: assert property (rd && ADR_I == 8'h24 |=> DAT_O[15:0] == NUM_INST && DAT_O[23:16] == SCALE
        && DAT_O[31] == (HAS_CAPTURE != 0) && DAT_O[30] == (HAS_LONG != 0))
        else $error("identification fields wrong");
    chk_long_hi_zero: assert property (rd && (ADR_I == 8'h18 || ADR_I == 8'h20) && LONG_WIDE_SEL == 0
        |=> DAT_O[30:12] == 19'h0)
        else $error("narrow long count upper bits not zero");
    chk_not_ready_flag_on_cfg: assert property (cfg_write ##1 (CAPTURE_EVENT == 0) [*2] ##1 ctr_read |=> DAT_O[31])
        else $error("config write did not set not ready");
endmodule
`default_nettype wire

// *** testbench/xfer_source.sv ***
// observed transfer and capture event source for the monitor bench
`timescale 1ns/1ns
`default_nettype none
module xfer_source (
    // clock
    input wire logic clk,
    // observed transfer and capture pulses
    output var logic valid,
    output var logic is_write,
    output var logic [15:0] part,
    output var logic [7:0] group,
    output var logic [7:0] bytes,
    output var logic [5:0] events
);
    // idle lines carry a pattern, never a count that could be mistaken for one
    initial
    begin
        {valid, is_write, part, group, bytes, events} = {2'b00, 16'ha5a5, 8'h5a, 8'ha5, 6'h00};
    end
    // one beat, then release with payload inverted; zero bytes means pulse only
    task send(input logic w, input logic [15:0] p, input logic [7:0] g, input logic [7:0] b, input logic [5:0] e);
        @(posedge clk);
        {valid, is_write, part, group, bytes, events} <= {b != 8'h00, w, p, g, b, e};
        @(posedge clk);
        {valid, part, bytes, events} <= {1'b0, ~p, ~b, 6'h00};
    endtask
endmodule
`default_nettype wire

// *** testbench/test_bandwidth_usage_monitor.sv ***
// self-checking bench for the bandwidth usage monitor
`timescale 1ns/1ns
`default_nettype none
module test_bandwidth_usage_monitor;
    localparam int S = 3;
    typedef struct packed {logic w; logic [15:0] p; logic [7:0] g; logic [7:0] b; logic hit;} row_t;
    logic clk, rst, cyc, stb, we;
    logic [7:0] adr;
    logic [31:0] wdat, q, acc;
    wire logic [31:0] rdat;
    wire logic ack, irq, valid, is_write;
    wire logic [15:0] part;
    wire logic [7:0] group, bytes;
    wire logic [5:0] events;
    int errors, num_checks;
    // the filter takes partition 12, group 5, reads and writes
    row_t rows [5] = '{'{1'b1, 16'h0012, 8'h05, 8'h40, 1'b1}, '{1'b0, 16'h0012, 8'h05, 8'h20, 1'b1},
        '{1'b1, 16'h0013, 8'h05, 8'h10, 1'b0}, '{1'b0, 16'h0012, 8'h06, 8'h08, 1'b0},
        '{1'b1, 16'h0012, 8'h05, 8'hff, 1'b1}};
    bw_usage_monitor #(.SCALE(S)) DUT (.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .XFER_VALID(valid), .XFER_IS_WRITE(is_write),
        .XFER_PARTITION_ID(part), .XFER_PERF_GROUP(group), .XFER_BYTES(bytes), .CAPTURE_EVENT(events),
        .OVERFLOW_IRQ(irq));
    xfer_source src (.clk(clk), .valid(valid), .is_write(is_write), .part(part), .group(group), .bytes(bytes),
        .events(events));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // a hung handshake would stall the run for good
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        close_out();
    end
    task close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // classic cycle: hold until ack is seen, take data there, then release
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    initial
    begin
        {cyc, stb, we, adr, wdat, acc} = '0;
        errors = 0;
        num_checks = 0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, 8'h18, 32'h0);
        chk("long hi at reset", 32'h80000000, q);
        wb(1'b1, 8'h04, 32'h80000200);
        wb(1'b1, 8'h08, 32'h0f050012);
        wb(1'b0, 8'h0c, 32'h0);
        chk("not ready", 32'h80000000, q);
        foreach (rows[i])
        begin
            src.send(rows[i].w, rows[i].p, rows[i].g, rows[i].b, 6'h00);
            if (rows[i].hit)
                acc = acc + rows[i].b;
            wb(1'b0, 8'h0c, 32'h0);
            chk("short count", {1'b1, acc[30:0]}, q);
        end
        wb(1'b0, 8'h14, 32'h0);
        chk("long count", acc, q);
        // capture with clear while a beat lands in the same cycle
        wb(1'b1, 8'h04, 32'h80000202);
        src.send(1'b1, 16'h0012, 8'h05, 8'h10, 6'h04);
        wb(1'b0, 8'h10, 32'h0);
        chk("short capture", {1'b1, acc[30:0]}, q);
        wb(1'b0, 8'h1c, 32'h0);
        chk("long capture", acc, q);
        wb(1'b0, 8'h0c, 32'h0);
        chk("count after clear", 32'h10, q);
        // scaled view rounds to the nearest unit; the long view stays in bytes
        wb(1'b1, 8'h04, 32'h80000201);
        src.send(1'b0, 16'h0012, 8'h05, 8'h0c, 6'h00);
        wb(1'b0, 8'h0c, 32'h0);
        chk("scaled count", 32'h80000000 | ((32'h1c + 32'h4) >> S), q);
        chk("scaled bytes", 32'h20, (q & 32'h7fffffff) << S);
        wb(1'b0, 8'h14, 32'h0);
        chk("long unscaled", 32'h1c, q);
        // local trigger fires only on its trigger bit
        wb(1'b1, 8'h04, 32'h80000700);
        wb(1'b1, 8'h0c, 32'h80000000);
        src.send(1'b0, 16'h0012, 8'h05, 8'h30, 6'h00);
        wb(1'b1, 8'h2c, 32'h2);
        wb(1'b0, 8'h10, 32'h0);
        chk("no trigger", {1'b1, acc[30:0]}, q);
        wb(1'b1, 8'h2c, 32'h1);
        wb(1'b0, 8'h10, 32'h0);
        chk("local capture", 32'h80000030, q);
        wb(1'b0, 8'h0c, 32'h0);
        chk("kept count", 32'h30, q);
        // short overflow: flag always, interrupt only when enabled
        wb(1'b1, 8'h04, 32'h80000008);
        wb(1'b1, 8'h0c, 32'h7ffffff0);
        src.send(1'b1, 16'h0012, 8'h05, 8'h20, 6'h00);
        wb(1'b0, 8'h04, 32'h0);
        chk("flag set", 32'h80000028, q);
        chk("irq raised", 32'h1, {31'h0, irq});
        wb(1'b1, 8'h04, 32'h80000000);
        wb(1'b0, 8'h04, 32'h0);
        chk("flag cleared", 32'h80000000, q);
        wb(1'b1, 8'h0c, 32'h7ffffff0);
        src.send(1'b1, 16'h0012, 8'h05, 8'h20, 6'h00);
        wb(1'b0, 8'h04, 32'h0);
        chk("masked flag", 32'h80000020, q);
        chk("irq masked", 32'h0, {31'h0, irq});
        // other instance untouched, then the edges of the map
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b0, 8'h0c, 32'h0);
        chk("other instance", 32'h80000000, q);
        wb(1'b0, 8'h30, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b0, 8'h24, 32'h0);
        chk("id reg", 32'hc0030004, q);
        close_out();
    end
endmodule
bind bw_usage_monitor bw_monitor_checker #(.NUM_INST(NUM_INST), .SCALE(SCALE), .HAS_LONG(HAS_LONG),
    .HAS_CAPTURE(HAS_CAPTURE), .LONG_WIDE_SEL(LONG_WIDE_SEL), .NUM_EXT_EVENTS(NUM_EXT_EVENTS)) u_chk (
    .CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .CAPTURE_EVENT(CAPTURE_EVENT));
`default_nettype wire
